// ===== hw/lfr_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module lfr_top
  import lfr_pkg::*;
#(
  parameter int COL_WINDOW = LFR_COL_WINDOW,
  parameter int SEQ_NEEDED = LFR_SEQ_NEEDED
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [LFR_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]           regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [31:0]           regRdData,
  input  wire logic [63:0]           rxData,
  input  wire logic [7:0]            rxCtrl,
  input  wire logic [63:0]           txClientData,
  input  wire logic [7:0]            txClientCtrl,
  output logic      [63:0]           txData,
  output logic      [7:0]            txCtrl,
  output logic                       remoteFaultStatus,
  output logic                       localFaultStatus,
  output logic                       unidirEn,
  output logic                       linkFaultGenEn,
  output logic                       irq
);

  // ---------------------------------------------------------------
  // Receive sequence detection
  // ---------------------------------------------------------------
  logic isSeq;
  logic isLocal;
  logic isRemote;

  lfr_seq_detect u_detect (
    .rxData   (rxData),
    .rxCtrl   (rxCtrl),
    .isSeq    (isSeq),
    .isLocal  (isLocal),
    .isRemote (isRemote)
  );

  // ---------------------------------------------------------------
  // Fault state machine
  // ---------------------------------------------------------------
  // One 64-bit word carries two columns; counts are kept in columns.
  lfr_fault_e   fault_ff;
  lfr_fault_e   nxt_fault;
  lfr_fault_e   cand_ff;
  lfr_fault_e   nxt_cand;
  logic [2:0]   seqCnt_ff;
  logic [2:0]   nxt_seqCnt;
  logic [LFR_COL_W:0] gapCol_ff;
  logic [LFR_COL_W:0] nxt_gapCol;
  logic [LFR_COL_W:0] okCol_ff;
  logic [LFR_COL_W:0] nxt_okCol;
  logic         faultSeen;
  lfr_fault_e   seenVal;
  logic         gapOk;
  logic         okReached;

  localparam logic [LFR_COL_W:0] COL_LIMIT = (LFR_COL_W+1)'(COL_WINDOW);
  localparam logic [2:0]         SEQ_LAST  = 3'(SEQ_NEEDED - 1);
  localparam logic [LFR_COL_W:0] COL_STEP  = (LFR_COL_W+1)'(2);

  always_comb begin
    faultSeen  = isLocal || isRemote;
    seenVal    = isLocal ? LFR_LOCAL : LFR_REMOTE;
    gapOk      = (gapCol_ff < COL_LIMIT);
    okReached  = (okCol_ff + COL_STEP >= COL_LIMIT);
    nxt_fault  = fault_ff;
    nxt_cand   = cand_ff;
    nxt_seqCnt = seqCnt_ff;
    nxt_gapCol = (gapCol_ff >= COL_LIMIT) ? gapCol_ff : gapCol_ff + COL_STEP;
    nxt_okCol  = okReached ? COL_LIMIT : okCol_ff + COL_STEP;
    if (faultSeen) begin
      nxt_gapCol = '0;
      nxt_okCol  = '0;
      if (cand_ff == seenVal && gapOk && seqCnt_ff != 3'h0) begin
        if (seqCnt_ff >= SEQ_LAST) begin
          nxt_fault  = seenVal;
          nxt_seqCnt = SEQ_LAST;
        end else begin
          // Count only; the state moves on the last sequence of the run
          nxt_seqCnt = seqCnt_ff + 3'h1;
        end
      end else begin
        // Different value or too late: restart the run
        nxt_cand   = seenVal;
        nxt_seqCnt = 3'h1;
        if (SEQ_LAST == 3'h0) begin
          nxt_fault = seenVal;
        end
      end
    end else if (okReached) begin
      nxt_fault  = LFR_OK;
      nxt_seqCnt = 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_ff  <= LFR_OK;
      cand_ff   <= LFR_OK;
      seqCnt_ff <= 3'h0;
      gapCol_ff <= '0;
      okCol_ff  <= '0;
    end else begin
      fault_ff  <= nxt_fault;
      cand_ff   <= nxt_cand;
      seqCnt_ff <= nxt_seqCnt;
      gapCol_ff <= nxt_gapCol;
      okCol_ff  <= nxt_okCol;
    end
  end

  // ---------------------------------------------------------------
  // Registers and interrupt
  // ---------------------------------------------------------------
  logic [1:0]  cfg_ff;
  logic [1:0]  nxt_cfg;
  logic [2:0]  evt_ff;
  logic [2:0]  nxt_evt;
  logic [2:0]  mask_ff;
  logic [2:0]  nxt_mask;
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  logic        irq_ff;
  logic        nxt_irq;
  logic [2:0]  evtSet;

  always_comb begin
    evtSet = 3'h0;
    evtSet[LFR_EVT_LOCAL_BIT]  = (nxt_fault == LFR_LOCAL) && (fault_ff != LFR_LOCAL);
    evtSet[LFR_EVT_REMOTE_BIT] = (nxt_fault == LFR_REMOTE) && (fault_ff != LFR_REMOTE);
    evtSet[LFR_EVT_OK_BIT]     = (nxt_fault == LFR_OK) && (fault_ff != LFR_OK);
    nxt_cfg  = cfg_ff;
    nxt_mask = mask_ff;
    nxt_evt  = evt_ff;
    nxt_rd   = 32'h0;
    if (regWr && regAddr == LFR_CFG_ADDR) begin
      nxt_cfg = regWrData[1:0];
    end
    if (regWr && regAddr == LFR_MASK_ADDR) begin
      nxt_mask = regWrData[2:0];
    end
    if (regRd) begin
      case (regAddr)
        LFR_CFG_ADDR:  nxt_rd = {30'h0, cfg_ff};
        LFR_STAT_ADDR: nxt_rd = {30'h0, fault_ff == LFR_REMOTE, fault_ff == LFR_LOCAL};
        LFR_IRQ_ADDR: begin
          nxt_rd  = {29'h0, evt_ff};
          nxt_evt = 3'h0;
        end
        LFR_MASK_ADDR: nxt_rd = {29'h0, mask_ff};
        default:       nxt_rd = 32'h0;
      endcase
    end
    // Set wins over the read-clear
    nxt_evt = nxt_evt | evtSet;
    nxt_irq = |(nxt_evt & nxt_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_ff  <= LFR_CFG_RESET;
      evt_ff  <= LFR_EVT_RESET;
      mask_ff <= LFR_EVT_RESET;
      rd_ff   <= 32'h0;
      irq_ff  <= 1'b0;
    end else begin
      cfg_ff  <= nxt_cfg;
      evt_ff  <= nxt_evt;
      mask_ff <= nxt_mask;
      rd_ff   <= nxt_rd;
      irq_ff  <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  logic [63:0] muxData;
  logic [7:0]  muxCtrl;
  logic [63:0] txData_ff;
  logic [7:0]  txCtrl_ff;

  lfr_tx_mux u_txmux (
    .cfgMode     (cfg_ff),
    .faultLocal  (fault_ff == LFR_LOCAL),
    .faultRemote (fault_ff == LFR_REMOTE),
    .clientData  (txClientData),
    .clientCtrl  (txClientCtrl),
    .muxData     (muxData),
    .muxCtrl     (muxCtrl)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      txData_ff <= LFR_IDLE_WORD;
      txCtrl_ff <= LFR_CTRL_ALL;
    end else begin
      txData_ff <= muxData;
      txCtrl_ff <= muxCtrl;
    end
  end

  // Status straight from fault state, config-independent
  assign remoteFaultStatus = (fault_ff == LFR_REMOTE);
  assign localFaultStatus  = (fault_ff == LFR_LOCAL);
  assign unidirEn          = cfg_ff[LFR_CFG_UNI_BIT];
  assign linkFaultGenEn    = cfg_ff[LFR_CFG_GEN_BIT];
  assign regRdData         = rd_ff;
  assign irq               = irq_ff;
  assign txData            = txData_ff;
  assign txCtrl            = txCtrl_ff;

endmodule
`default_nettype wire

// ===== pkg/lfr_pkg.sv
package lfr_pkg;

  // ---------------------------------------------------------------
  // Register map (word index; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] LFR_CFG_IDX    = 12'h405;
  localparam logic [11:0] LFR_STAT_IDX   = 12'h406;
  localparam logic [11:0] LFR_IRQ_IDX    = 12'h407;
  localparam logic [11:0] LFR_MASK_IDX   = 12'h408;
  localparam int          LFR_ADDR_W     = 14;
  localparam logic [13:0] LFR_CFG_ADDR   = {LFR_CFG_IDX, 2'b00};
  localparam logic [13:0] LFR_STAT_ADDR  = {LFR_STAT_IDX, 2'b00};
  localparam logic [13:0] LFR_IRQ_ADDR   = {LFR_IRQ_IDX, 2'b00};
  localparam logic [13:0] LFR_MASK_ADDR  = {LFR_MASK_IDX, 2'b00};

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int          LFR_CFG_GEN_BIT   = 0;
  localparam int          LFR_CFG_UNI_BIT   = 1;
  localparam logic [1:0]  LFR_CFG_RESET     = 2'h0;
  localparam logic [1:0]  LFR_MODE_BIDIR    = 2'h1;
  localparam logic [1:0]  LFR_MODE_UNIDIR   = 2'h3;
  localparam int          LFR_EVT_LOCAL_BIT = 0;
  localparam int          LFR_EVT_REMOTE_BIT = 1;
  localparam int          LFR_EVT_OK_BIT    = 2;
  localparam logic [2:0]  LFR_EVT_RESET     = 3'h0;

  // ---------------------------------------------------------------
  // Ordered-set coding on the 64-bit lane
  // ---------------------------------------------------------------
  localparam logic [7:0]  LFR_SEQ_CODE   = 8'h9C;
  localparam logic [7:0]  LFR_IDLE_CODE  = 8'h07;
  localparam logic [7:0]  LFR_LOCAL_VAL  = 8'h01;
  localparam logic [7:0]  LFR_REMOTE_VAL = 8'h02;
  localparam logic [63:0] LFR_IDLE_WORD  = {8{LFR_IDLE_CODE}};
  localparam logic [7:0]  LFR_CTRL_ALL   = 8'hFF;

  // ---------------------------------------------------------------
  // Sequence and column counts
  // ---------------------------------------------------------------
  localparam int          LFR_SEQ_NEEDED = 4;
  localparam int          LFR_COL_WINDOW = 128;
  localparam int          LFR_COL_W      = 8;

  typedef enum logic [1:0] {
    LFR_OK     = 2'b00,
    LFR_LOCAL  = 2'b01,
    LFR_REMOTE = 2'b10
  } lfr_fault_e;

endpackage

// ===== hw/lfr_seq_detect.sv
`timescale 1ns/1ns
`default_nettype none
module lfr_seq_detect
  import lfr_pkg::*;
(
  input  wire logic [63:0] rxData,
  input  wire logic [7:0]  rxCtrl,
  output var  logic        isSeq,
  output var  logic        isLocal,
  output var  logic        isRemote
);
  // Sequence set in either 32-bit half (lane 0 or lane 4)
  logic seqLo;
  logic seqHi;
  always_comb begin
    seqLo    = rxCtrl[0] && (rxCtrl[3:1] == 3'h0) && (rxData[7:0] == LFR_SEQ_CODE);
    seqHi    = rxCtrl[4] && (rxCtrl[7:5] == 3'h0) && (rxData[39:32] == LFR_SEQ_CODE);
    isSeq    = seqLo || seqHi;
    isLocal  = (seqLo && rxData[31:24] == LFR_LOCAL_VAL)
            || (seqHi && rxData[63:56] == LFR_LOCAL_VAL);
    isRemote = (seqLo && rxData[31:24] == LFR_REMOTE_VAL)
            || (seqHi && rxData[63:56] == LFR_REMOTE_VAL);
  end
endmodule
`default_nettype wire

// ===== hw/lfr_tx_mux.sv
`timescale 1ns/1ns
`default_nettype none
module lfr_tx_mux
  import lfr_pkg::*;
(
  input  wire logic [1:0]  cfgMode,
  input  wire logic        faultLocal,
  input  wire logic        faultRemote,
  input  wire logic [63:0] clientData,
  input  wire logic [7:0]  clientCtrl,
  output var  logic [63:0] muxData,
  output var  logic [7:0]  muxCtrl
);
  logic [63:0] faultSeq;
  logic        isIdle;
  always_comb begin
    faultSeq = {LFR_LOCAL_VAL, 16'h0000, LFR_SEQ_CODE,
                LFR_LOCAL_VAL, 16'h0000, LFR_SEQ_CODE};
    if (faultLocal) begin
      faultSeq[31:24] = LFR_REMOTE_VAL;
      faultSeq[63:56] = LFR_REMOTE_VAL;
    end
    isIdle  = (clientCtrl == LFR_CTRL_ALL) && (clientData == LFR_IDLE_WORD);
    muxData = clientData;
    muxCtrl = clientCtrl;
    if (cfgMode[LFR_CFG_GEN_BIT]) begin
      if (faultLocal) begin
        // Remote fault sent in place of frames and idles; with the unidirectional bit set, in place of idles only
        if (!cfgMode[LFR_CFG_UNI_BIT] || isIdle) begin
          muxData = {faultSeq[63:56], 16'h0000, LFR_SEQ_CODE,
                     faultSeq[31:24], 16'h0000, LFR_SEQ_CODE};
          muxCtrl = 8'h11;
        end
      end else if (faultRemote) begin
        if (cfgMode == LFR_MODE_BIDIR) begin
          muxData = LFR_IDLE_WORD;
          muxCtrl = LFR_CTRL_ALL;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/lfr_pcs_model.sv
`timescale 1ns/1ns
`default_nettype none
module lfr_pcs_model
  import lfr_pkg::*;
(
  input  wire logic [1:0]  kind,
  output var  logic [63:0] rxData,
  output var  logic [7:0]  rxCtrl
);
  // ----------------------------------------------------
  // Kind 0 idle, 1 local, 2 remote, 3 client data
  // ----------------------------------------------------
  always_comb begin
    rxData = LFR_IDLE_WORD;
    rxCtrl = LFR_CTRL_ALL;
    if (kind == 2'h3) begin
      rxData = 64'h5A5A5A5A5A5A5A5A;
      rxCtrl = 8'h00;
    end else if (kind != 2'h0) begin
      rxData[31:0] = {((kind == 2'h1) ? LFR_LOCAL_VAL : LFR_REMOTE_VAL), 16'h0000, LFR_SEQ_CODE};
      rxCtrl = 8'hF1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/lfr_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module lfr_assertions
  import lfr_pkg::*;
#(
  parameter int COL_WINDOW = LFR_COL_WINDOW,
  parameter int SEQ_NEEDED = LFR_SEQ_NEEDED
) (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic [LFR_ADDR_W-1:0] regAddr,
  input wire logic [31:0]           regWrData,
  input wire logic                  regWr,
  input wire logic [63:0]           rxData,
  input wire logic [7:0]            rxCtrl,
  input wire logic [63:0]           txClientData,
  input wire logic [7:0]            txClientCtrl,
  input wire logic [63:0]           txData,
  input wire logic [7:0]            txCtrl,
  input wire logic                  remoteFaultStatus,
  input wire logic                  localFaultStatus,
  input wire logic                  unidirEn,
  input wire logic                  linkFaultGenEn
);
  localparam logic [63:0] REM_SEQ   = {2{LFR_REMOTE_VAL, 16'h0000, LFR_SEQ_CODE}};
  localparam logic [7:0]  QUIET_END = 8'(COL_WINDOW / 2 + 2);
  logic       cfgWr;
  logic       locW;
  logic       faultW;
  logic [1:0] mode;
  logic [7:0] quietCnt_ff;
  logic [7:0] nxt_quietCnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  assign cfgWr  = regWr && (regAddr == LFR_CFG_ADDR);
  assign mode   = {unidirEn, linkFaultGenEn};
  assign locW   = (rxCtrl == 8'hF1)
               && (rxData == {LFR_IDLE_WORD[63:32], LFR_LOCAL_VAL, 16'h0000, LFR_SEQ_CODE});
  assign faultW = (rxCtrl[0] && rxData[7:0] == LFR_SEQ_CODE)
               || (rxCtrl[4] && rxData[39:32] == LFR_SEQ_CODE);
  // ----------------------------------------------------
  // Quiet words; saturates so it never wraps
  // ----------------------------------------------------
  always_comb begin
    nxt_quietCnt = quietCnt_ff;
    if (faultW) begin
      nxt_quietCnt = 8'h00;
    end else if (quietCnt_ff != 8'hFF) begin
      nxt_quietCnt = quietCnt_ff + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    quietCnt_ff <= reset ? 8'h00 : nxt_quietCnt;
  end
  sequence fourLocal;
    locW [*4];
  endsequence
  gen_follow_a: assert property (cfgWr |=> linkFaultGenEn == $past(regWrData[0]))
    else $error("gen enable not config bit 0");
  uni_follow_a: assert property (cfgWr |=> unidirEn == $past(regWrData[1]))
    else $error("unidir enable not config bit 1");
  cfg_hold_a: assert property (!cfgWr |=> $stable(mode))
    else $error("config moved without a write");
  pass_a: assert property ((!linkFaultGenEn) [*2] |=>
    txData == $past(txClientData) && txCtrl == $past(txClientCtrl))
    else $error("disabled path altered traffic");
  bidir_loc_a: assert property ((localFaultStatus && mode == LFR_MODE_BIDIR) [*2] |=>
    txData == REM_SEQ && txCtrl == 8'h11)
    else $error("local fault not answered by remote seq");
  bidir_rem_a: assert property ((remoteFaultStatus && mode == LFR_MODE_BIDIR) [*2] |=>
    txData == LFR_IDLE_WORD && txCtrl == LFR_CTRL_ALL)
    else $error("remote fault not answered by idles");
  unidir_a: assert property ((localFaultStatus && mode == LFR_MODE_UNIDIR) [*2] ##0
    (txClientCtrl == LFR_CTRL_ALL && txClientData == LFR_IDLE_WORD) |=>
    txData == REM_SEQ && txCtrl == 8'h11)
    else $error("gap not filled with remote seq");
  local_raise_a: assert property (fourLocal |=> localFaultStatus)
    else $error("four local seqs did not raise flag");
  rise_cause_a: assert property ($rose(localFaultStatus) |-> $past(locW))
    else $error("local flag rose without local seq");
  quiet_clear_a: assert property (quietCnt_ff == QUIET_END |->
    !localFaultStatus && !remoteFaultStatus)
    else $error("flags held over a quiet window");
endmodule
bind lfr_top lfr_assertions #(.COL_WINDOW(COL_WINDOW), .SEQ_NEEDED(SEQ_NEEDED)) i_lfr_assertions (
  .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .rxData(rxData), .rxCtrl(rxCtrl), .txClientData(txClientData), .txClientCtrl(txClientCtrl),
  .txData(txData), .txCtrl(txCtrl), .remoteFaultStatus(remoteFaultStatus),
  .localFaultStatus(localFaultStatus), .unidirEn(unidirEn), .linkFaultGenEn(linkFaultGenEn));
`default_nettype wire

// ===== bench/tb_lfr_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_lfr_top
  import lfr_pkg::*;
;
  localparam logic [63:0] CLI_D   = 64'h0123456789ABCDEF;
  localparam logic [63:0] REM_SEQ = {2{LFR_REMOTE_VAL, 16'h0000, LFR_SEQ_CODE}};
  logic        mclk = 1'b0;
  logic        reset, regWr, regRd, irq, unidirEn, linkFaultGenEn;
  logic        remoteFaultStatus, localFaultStatus;
  logic [13:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [63:0] rxData, txClientData, txData;
  logic [7:0]  rxCtrl, txClientCtrl, txCtrl;
  logic [1:0]  kind;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  always #20 mclk = ~mclk;
  lfr_top #(.COL_WINDOW(LFR_COL_WINDOW), .SEQ_NEEDED(LFR_SEQ_NEEDED)) i_lfr_top (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .rxData(rxData), .rxCtrl(rxCtrl),
    .txClientData(txClientData), .txClientCtrl(txClientCtrl), .txData(txData), .txCtrl(txCtrl),
    .remoteFaultStatus(remoteFaultStatus), .localFaultStatus(localFaultStatus),
    .unidirEn(unidirEn), .linkFaultGenEn(linkFaultGenEn), .irq(irq));
  lfr_pcs_model i_lfr_pcs_model (.kind(kind), .rxData(rxData), .rxCtrl(rxCtrl));
  // ----------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [13:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(nm, exp, regRdData);
  endtask
  // Link falls back to client data so quiet spans are valid data
  task automatic send(input logic [1:0] k, input int n);
    repeat (n) begin
      @(posedge mclk);
      kind <= k;
    end
    @(posedge mclk);
    kind <= 2'h3;
  endtask
  task automatic flags(input string nm, input logic [1:0] lr);
    @(negedge mclk);
    chk(nm, lr, {localFaultStatus, remoteFaultStatus});
  endtask
  task automatic txchk(input string nm, input logic [63:0] d, input logic [7:0] c);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(nm, {c, d}, {txCtrl, txData});
  endtask
  task automatic test_regs();
    rdchk("config reset", LFR_CFG_ADDR, 32'h0);
    rdchk("unmapped", 14'h0000, 32'h0);
    wr(LFR_CFG_ADDR, 32'hFFFFFFFF);
    rdchk("config ones", LFR_CFG_ADDR, 32'h3);
    chk("enables", 2'h3, {unidirEn, linkFaultGenEn});
    wr(LFR_CFG_ADDR, 32'h1);
    @(negedge mclk);
    chk("bidir", LFR_MODE_BIDIR, {unidirEn, linkFaultGenEn});
    wr(LFR_CFG_ADDR, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_raise();
    send(2'h1, 3);
    send(2'h2, 1);
    send(2'h1, 3);
    flags("restarted", 2'h0);
    send(2'h1, 1);
    flags("local raised", 2'h2);
    rdchk("status", LFR_STAT_ADDR, 32'h1);
    repeat (60) @(posedge mclk);
    flags("still local", 2'h2);
    repeat (6) @(posedge mclk);
    flags("cleared", 2'h0);
    send(2'h1, 1);
    repeat (61) @(posedge mclk);
    send(2'h1, 3);
    flags("gap 126", 2'h2);
    repeat (68) @(posedge mclk);
    $display("test_raise done");
  endtask
  task automatic test_irq();
    wr(LFR_MASK_ADDR, 32'h2);
    rdchk("events", LFR_IRQ_ADDR, 32'h5);
    chk("masked", 1'b0, irq);
    send(2'h2, 4);
    flags("remote raised", 2'h1);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("irq set", 1'b1, irq);
    rdchk("events remote", LFR_IRQ_ADDR, 32'h2);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("irq cleared", 1'b0, irq);
    $display("test_irq done");
  endtask
  task automatic test_tx();
    @(posedge mclk);
    txClientData <= CLI_D;
    wr(LFR_CFG_ADDR, 32'h1);
    txchk("remote idles", LFR_IDLE_WORD, LFR_CTRL_ALL);
    send(2'h1, 4);
    txchk("local seq", REM_SEQ, 8'h11);
    wr(LFR_CFG_ADDR, 32'h3);
    txchk("unidir data", CLI_D, 8'h00);
    @(posedge mclk);
    txClientData <= LFR_IDLE_WORD;
    txClientCtrl <= LFR_CTRL_ALL;
    txchk("unidir gap", REM_SEQ, 8'h11);
    @(posedge mclk);
    txClientData <= CLI_D;
    txClientCtrl <= 8'h00;
    wr(LFR_CFG_ADDR, 32'h0);
    txchk("disabled", CLI_D, 8'h00);
    $display("test_tx done");
  endtask
  initial begin
    reset = 1'b1;
    regAddr = 14'h0000;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    kind = 2'h3;
    txClientData = 64'h0;
    txClientCtrl = 8'h00;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    test_regs();
    test_raise();
    test_irq();
    test_tx();
    complete_run();
  end
endmodule
`default_nettype wire
